// ---- rtl/sct_regs.sv ----
module sct_regs #(
    parameter int         PAT_W  = 14,
    parameter logic [7:0] REV_ID = 8'h5a  // Arbitrary value
) (
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire sct_pkg::sct_pins_s    pins,
    output logic                       serial_out_line_o,
    output logic                       serial_out_line_oe,
    input  wire logic [PAT_W-1:0]      pattern_copy_a,
    input  wire logic [PAT_W-1:0]      pattern_copy_b,
    input  wire logic [PAT_W-1:0]      pattern_copy_c,
    output logic [PAT_W-1:0]           pattern_out,
    output logic [5:0]                 test_code_low,
    output sct_pkg::sct_test_ctl_s     test_ctl,
    output logic                       auto_read_dis
);

    // Refuse widths the pattern path cannot carry
    if (PAT_W < 1 || PAT_W > 32) begin : g_bad_pat_w
        $error("PAT_W out of range");
    end

    // Bitwise majority of three copies
    function automatic logic [7:0] vote8(input logic [7:0] a, input logic [7:0] b,
                                         input logic [7:0] c);
        vote8 = (a & b) | (a & c) | (b & c);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection

    sct_pkg::sct_pins_s meta_q;
    sct_pkg::sct_pins_s sync_q;
    sct_pkg::sct_pins_s prev_q;

    // Two flops on every pin, then a delayed copy for edges
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta_q <= '{sclk: 1'b0, sen_n: 1'b1, sdi: 1'b0};
            sync_q <= '{sclk: 1'b0, sen_n: 1'b1, sdi: 1'b0};
            prev_q <= '{sclk: 1'b0, sen_n: 1'b1, sdi: 1'b0};
        end else begin
            meta_q <= pins;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic frame_start;
    logic frame_end;

    // Edge strobes
    assign sclk_rise   = sync_q.sclk & ~prev_q.sclk;
    assign sclk_fall   = ~sync_q.sclk & prev_q.sclk;
    assign frame_start = ~sync_q.sen_n & prev_q.sen_n;
    assign frame_end   = sync_q.sen_n & ~prev_q.sen_n;

    ////////////////////////////////////////////////////////////////////////////
    // Triplicated register bank and voting

    logic [7:0] bank_q [3][3];
    logic [7:0] voted  [3];
    logic [7:0] eff    [3];
    logic       ser_vote_off;

    // Majority of the three copies of each register
    always_comb begin
        for (int r = 0; r < 3; r++) begin
            voted[r] = vote8(bank_q[0][r], bank_q[1][r], bank_q[2][r]);
        end
    end

    assign ser_vote_off = voted[sct_pkg::IDX_TST][sct_pkg::SER_VOTE_BIT];

    // Voted or first copy per serial voting switch
    always_comb begin
        for (int r = 0; r < 3; r++) begin
            eff[r] = ser_vote_off ? bank_q[0][r] : voted[r];
        end
    end

    // Read decode, unmapped reads return zero
    function automatic logic [7:0] read_reg(input logic [5:0] addr, input logic [7:0] pat,
                                            input logic [7:0] ser, input logic [7:0] tst);
        unique case (addr)
            sct_pkg::ADDR_PAT_LOW:  read_reg = pat;
            sct_pkg::ADDR_SER_CFG:  read_reg = ser;
            sct_pkg::ADDR_TEST_CTL: read_reg = tst;
            sct_pkg::ADDR_REV_ID:   read_reg = REV_ID;
            default:                read_reg = 8'h00;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Serial frame engine

    // Local names for the frame states
    localparam sct_pkg::sct_ser_e SER_IDLE   = sct_pkg::SER_IDLE;
    localparam sct_pkg::sct_ser_e SER_ACTIVE = sct_pkg::SER_ACTIVE;

    sct_pkg::sct_ser_e state_q;
    logic [4:0]        cnt_q;
    logic [14:0]       in_q;
    logic [7:0]        out_q;
    logic              drive_q;
    logic [5:0]        last_addr_q;
    logic              last_read_q;
    logic [15:0]       word;
    logic              word_done;
    logic              auto_mode;

    assign word      = {in_q, sync_q.sdi};
    assign word_done = (state_q == SER_ACTIVE) && sclk_rise && (cnt_q == sct_pkg::LAST_CNT);
    assign auto_mode = ~eff[sct_pkg::IDX_SER][sct_pkg::AUTO_RD_DIS_BIT];

    // Frame state and bit count
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q <= SER_IDLE;
            cnt_q   <= 5'h00;
        end else begin
            unique case (state_q)
                SER_IDLE: begin
                    if (frame_start) begin
                        state_q <= SER_ACTIVE;
                        cnt_q   <= 5'h00;
                    end
                end
                SER_ACTIVE: begin
                    if (frame_end || word_done) begin
                        state_q <= SER_IDLE;
                    end else if (sclk_rise) begin
                        cnt_q <= cnt_q + 5'h01;
                    end
                end
            endcase
        end
    end

    // Input shift register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            in_q <= 15'h0000;
        end else if (state_q == SER_ACTIVE && sclk_rise) begin
            in_q <= word[14:0];
        end
    end

    // Address and kind of the last completed frame
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            last_addr_q <= 6'h00;
            last_read_q <= 1'b0;
        end else if (word_done) begin
            last_addr_q <= word[sct_pkg::ADDR_LSB +: 6];
            last_read_q <= word[sct_pkg::RW_BIT];
        end
    end

    // Read data load at frame start, shifted out on falling edges
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            out_q   <= 8'h00;
            drive_q <= 1'b0;
        end else if (state_q == SER_IDLE && frame_start) begin
            out_q   <= read_reg(last_addr_q, eff[0], eff[1], eff[2]);
            drive_q <= auto_mode | last_read_q;
        end else if (state_q == SER_ACTIVE && sclk_fall && cnt_q != 5'h00) begin
            out_q <= {out_q[6:0], 1'b0};
        end
    end

    // Output drives only in the first eight clocks
    assign serial_out_line_o  = out_q[7];
    assign serial_out_line_oe = drive_q && (state_q == SER_ACTIVE)
                                && (cnt_q < sct_pkg::OUT_BITS);

    // Register writes land in all three copies
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            for (int k = 0; k < 3; k++) begin
                bank_q[k][sct_pkg::IDX_PAT] <= sct_pkg::RST_PAT_LOW;
                bank_q[k][sct_pkg::IDX_SER] <= sct_pkg::RST_SER_CFG;
                bank_q[k][sct_pkg::IDX_TST] <= sct_pkg::RST_TEST_CTL;
            end
        end else if (word_done && !word[sct_pkg::RW_BIT]) begin
            for (int k = 0; k < 3; k++) begin
                unique case (word[sct_pkg::ADDR_LSB +: 6])
                    sct_pkg::ADDR_PAT_LOW:  bank_q[k][sct_pkg::IDX_PAT] <= word[7:0];
                    sct_pkg::ADDR_SER_CFG:  bank_q[k][sct_pkg::IDX_SER] <= word[7:0];
                    sct_pkg::ADDR_TEST_CTL: bank_q[k][sct_pkg::IDX_TST] <= word[7:0];
                    default: ;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control outputs and pattern path

    // Decoded controls from effective registers, serial voting switch from the voted copy
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            test_ctl      <= '0;
            test_code_low <= 6'h00;
            auto_read_dis <= 1'b0;
        end else begin
            test_ctl.pattern_vote_off <= eff[sct_pkg::IDX_TST][sct_pkg::PAT_VOTE_BIT];
            test_ctl.serial_vote_off  <= ser_vote_off;
            test_ctl.test_reset       <= eff[sct_pkg::IDX_TST][sct_pkg::TEST_RST_BIT];
            test_ctl.test_enable      <= eff[sct_pkg::IDX_TST][sct_pkg::TEST_EN_BIT];
            test_code_low <= eff[sct_pkg::IDX_PAT][sct_pkg::CODE_LOW_W-1:0];
            auto_read_dis <= ~auto_mode;
        end
    end

    logic [PAT_W-1:0] pat_vote;

    assign pat_vote = (pattern_copy_a & pattern_copy_b) | (pattern_copy_a & pattern_copy_c)
                    | (pattern_copy_b & pattern_copy_c);

    // Pattern out: gated by enable, cleared by test reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pattern_out <= '0;
        end else if (!test_ctl.test_enable || test_ctl.test_reset) begin
            pattern_out <= '0;
        end else begin
            pattern_out <= test_ctl.pattern_vote_off ? pattern_copy_a : pat_vote;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    a_code_low_follow: assert property (@(posedge mclk) disable iff (rst)
        1'b1 |=> test_code_low == $past(eff[sct_pkg::IDX_PAT][5:0]))
        else $error("test code low does not follow register");

    a_auto_drive: assert property (@(posedge mclk) disable iff (rst)
        (state_q == SER_IDLE && frame_start && auto_mode) ##1 (state_q == SER_ACTIVE)
        |-> serial_out_line_oe)
        else $error("auto read not driving at frame start");

    a_auto_addr: assert property (@(posedge mclk) disable iff (rst)
        word_done |=> last_addr_q == $past(word[13:8]))
        else $error("previous address not kept");

    a_manual_read: assert property (@(posedge mclk) disable iff (rst)
        (state_q == SER_IDLE && frame_start && last_read_q) |=> drive_q)
        else $error("manual read not answered");

    a_write_release: assert property (@(posedge mclk) disable iff (rst)
        (state_q == SER_IDLE && frame_start && !auto_mode && !last_read_q)
        |=> !serial_out_line_oe [*2])
        else $error("output driven after write in manual mode");

    a_oe_window: assert property (@(posedge mclk) disable iff (rst)
        serial_out_line_oe |-> cnt_q < sct_pkg::OUT_BITS)
        else $error("output driven past eight clocks");

    a_oe_stop: assert property (@(posedge mclk) disable iff (rst)
        (state_q == SER_ACTIVE && sclk_rise && cnt_q == sct_pkg::OUT_BITS - 5'h01)
        |=> !serial_out_line_oe)
        else $error("output still driven after eighth clock");

    a_pat_first: assert property (@(posedge mclk) disable iff (rst)
        (test_ctl.test_enable && !test_ctl.test_reset && test_ctl.pattern_vote_off)
        |=> pattern_out == $past(pattern_copy_a))
        else $error("pattern copy select wrong");

    a_pat_vote: assert property (@(posedge mclk) disable iff (rst)
        (test_ctl.test_enable && !test_ctl.test_reset && !test_ctl.pattern_vote_off)
        |=> pattern_out == $past(pat_vote))
        else $error("pattern vote wrong");

    a_pat_gate: assert property (@(posedge mclk) disable iff (rst)
        !test_ctl.test_enable |=> pattern_out == '0)
        else $error("pattern out while test disabled");

    a_reset_sticky: assert property (@(posedge mclk) disable iff (rst)
        $fell(test_ctl.test_reset)
        |-> $past(word_done, 2) && !$past(word[sct_pkg::RW_BIT], 2))
        else $error("test reset cleared itself");

    c_auto_read:  cover property (@(posedge mclk) word_done && word[sct_pkg::RW_BIT] && auto_mode);
    c_manual_rd:  cover property (@(posedge mclk) frame_start && !auto_mode && last_read_q);
    c_write_tst:  cover property (@(posedge mclk) word_done && !word[sct_pkg::RW_BIT]
                                  && word[13:8] == sct_pkg::ADDR_TEST_CTL);
    c_pattern_on: cover property (@(posedge mclk) test_ctl.test_enable && pattern_out != '0);
    c_manual_wr:  cover property (@(posedge mclk) frame_start && !auto_mode && !last_read_q);

endmodule

// ---- rtl/sct_pkg.sv ----
package sct_pkg;

    // Register offsets on the serial port (six address bits)
    localparam logic [5:0] ADDR_PAT_LOW  = 6'h39;
    localparam logic [5:0] ADDR_SER_CFG  = 6'h3c;
    localparam logic [5:0] ADDR_TEST_CTL = 6'h3d;
    localparam logic [5:0] ADDR_REV_ID   = 6'h3e;

    // Baseline values
    localparam logic [7:0] RST_PAT_LOW  = 8'h00;
    localparam logic [7:0] RST_SER_CFG  = 8'h00;
    localparam logic [7:0] RST_TEST_CTL = 8'h00;

    // Field positions
    localparam int AUTO_RD_DIS_BIT = 0;
    localparam int PAT_VOTE_BIT    = 5;
    localparam int SER_VOTE_BIT    = 4;
    localparam int TEST_RST_BIT    = 2;
    localparam int TEST_EN_BIT     = 1;
    localparam int CODE_LOW_W      = 6;

    // Frame layout: read flag, 7 address bits (low 6 used), 8 data bits
    localparam int          FRAME_BITS = 16;
    localparam int          RW_BIT     = 15;
    localparam int          ADDR_LSB   = 8;
    localparam logic [4:0]  OUT_BITS   = 5'h08;
    localparam logic [4:0]  LAST_CNT   = 5'h0f;

    // Index of each writable register inside one bank copy
    localparam logic [1:0] IDX_PAT = 2'h0;
    localparam logic [1:0] IDX_SER = 2'h1;
    localparam logic [1:0] IDX_TST = 2'h2;

    typedef enum logic {SER_IDLE, SER_ACTIVE} sct_ser_e;

    // Decoded test and voting controls
    typedef struct packed {
        logic pattern_vote_off;
        logic serial_vote_off;
        logic test_reset;
        logic test_enable;
    } sct_test_ctl_s;

    // Serial pins as sampled from outside
    typedef struct packed {
        logic sclk;
        logic sen_n;
        logic sdi;
    } sct_pins_s;

endpackage

// ---- bench/sct_host.sv ----
// Host controller model: drives frames on the serial pins and samples read data
module sct_host (
    output logic      sclk,
    output logic      sen_n,
    output logic      sdi,
    input  wire logic sdo_o,
    input  wire logic sdo_oe
);
    timeunit 1ns;
    timeprecision 100ps;

    // Link idles with clock low and frame released
    initial begin
        sclk = 1'b0;
        sen_n = 1'b1;
        sdi = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One 16-bit frame, msb first; read data sampled at the end of each of the first eight low phases
    task automatic xfer(input logic [15:0] frame, output logic [7:0] rd,
                        output logic [7:0] en);
        logic line;
        sen_n = 1'b0;
        sdi = frame[15];
        #200;
        for (int i = 15; i >= 0; i--) begin
            sdi = frame[i];
            #125;
            line = sdo_oe ? sdo_o : 1'bz; // Wire level from the device enable
            if (i >= 8) begin
                rd[i-8] = line;
                en[i-8] = sdo_oe;
            end
            sclk = 1'b1;
            #75;
            sclk = 1'b0;
        end
        #100;
        sen_n = 1'b1;
        sdi = ~sdi; // Released line must not keep its last value
        #250;
    endtask
endmodule

// ---- bench/serial_config_test_control_tb_top.sv ----
// Bench for the serial configuration and test control registers
module serial_config_test_control_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int         DLY = 2;
    localparam logic [7:0] REV = 8'h3c; // Arbitrary identifier value

    logic                  mclk = 1'b0;
    logic                  rst = 1'b1;
    logic                  h_sclk;
    logic                  h_sen_n;
    logic                  h_sdi;
    sct_pkg::sct_pins_s    pins;
    logic                  sdo_o;
    logic                  sdo_oe;
    logic [13:0]           ca = 14'h0f0f;
    logic [13:0]           cb = 14'h00ff;
    logic [13:0]           cc = 14'h3333;
    logic [13:0]           pattern_out;
    logic [5:0]            test_code_low;
    sct_pkg::sct_test_ctl_s test_ctl;
    logic                  auto_read_dis;
    logic [7:0]            rdv;
    logic [7:0]            env;
    logic [7:0]            prev;
    logic [7:0]            v;
    logic [7:0]            vals [5] = '{8'h02, 8'h22, 8'h12, 8'h26, 8'h00};
    logic [13:0]           ep;
    int                    num_errors = 0;
    int                    checks = 0;
    int                    cycles = 0;

    assign pins = {h_sclk, h_sen_n, h_sdi};

    always #12.5 mclk = ~mclk;

    sct_host u_host (.sclk(h_sclk), .sen_n(h_sen_n), .sdi(h_sdi), .sdo_o(sdo_o),
                     .sdo_oe(sdo_oe));

    sct_regs #(.PAT_W(14), .REV_ID(REV)) dut (
        .mclk(mclk), .rst(rst), .pins(pins), .serial_out_line_o(sdo_o),
        .serial_out_line_oe(sdo_oe), .pattern_copy_a(ca), .pattern_copy_b(cb),
        .pattern_copy_c(cc), .pattern_out(pattern_out), .test_code_low(test_code_low),
        .test_ctl(test_ctl), .auto_read_dis(auto_read_dis)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic frm(input logic rw, input logic [5:0] a, input logic [7:0] d);
        @(posedge mclk);
        #DLY;
        u_host.xfer({rw, 1'b0, a, d}, rdv, env);
    endtask

    task automatic report_and_stop();
        if (num_errors == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (10) @(posedge mclk);
        #DLY rst = 1'b0;
        repeat (3) @(posedge mclk);
        #DLY;
        chk("test_code_low", 16'h0000, 16'(test_code_low));
        chk("test_ctl", 16'h0000, 16'(test_ctl));
        chk("auto_read_dis", 16'h0000, 16'(auto_read_dis));
        // Baselines read back in automatic mode
        frm(1'b1, sct_pkg::ADDR_PAT_LOW, 8'h00);
        chk("rd unmapped", 16'h00ff, {rdv, env});
        frm(1'b1, sct_pkg::ADDR_SER_CFG, 8'h00);
        chk("rd pat_low", 16'h0000, {rdv, env}^16'h00ff);
        frm(1'b1, sct_pkg::ADDR_TEST_CTL, 8'h00);
        chk("rd ser_cfg", 16'h0000, 16'(rdv));
        frm(1'b1, sct_pkg::ADDR_REV_ID, 8'h00);
        chk("rd test_ctl", 16'h0000, 16'(rdv));
        frm(1'b0, sct_pkg::ADDR_REV_ID, 8'h00);
        chk("rd rev", 16'(REV), 16'(rdv));
        frm(1'b0, sct_pkg::ADDR_PAT_LOW, 8'h15);
        chk("rd rev after write", 16'(REV), 16'(rdv));
        chk("test_code_low", 16'h0015, 16'(test_code_low));
        frm(1'b1, sct_pkg::ADDR_TEST_CTL, 8'h00);
        chk("rd after write", 16'h15ff, {rdv, env});
        // Test controls, voting and pattern gating
        prev = 8'h00;
        for (int k = 0; k < 5; k++) begin
            v = vals[k];
            frm(1'b0, sct_pkg::ADDR_TEST_CTL, v);
            chk("rd test_ctl", 16'(prev), 16'(rdv));
            ep = v[5] ? ca : ((ca & cb) | (ca & cc) | (cb & cc));
            ep = (v[1] && !v[2]) ? ep : 14'h0000;
            repeat (3) @(posedge mclk);
            #DLY;
            chk("pattern_out", 16'(ep), 16'(pattern_out));
            chk("test_ctl", {12'h000, v[5], v[4], v[2], v[1]}, 16'(test_ctl));
            prev = v;
        end
        // Read-back with automatic read disabled, then re-enabled for the last read
        frm(1'b0, sct_pkg::ADDR_SER_CFG, 8'h01);
        chk("auto_read_dis", 16'h0001, 16'(auto_read_dis));
        frm(1'b1, sct_pkg::ADDR_PAT_LOW, 8'h00);
        chk("oe after write", 16'h0000, 16'(env));
        frm(1'b1, sct_pkg::ADDR_REV_ID, 8'h00);
        chk("manual rd pat_low", 16'h15ff, {rdv, env});
        frm(1'b0, sct_pkg::ADDR_TEST_CTL, 8'h00);
        chk("manual rd rev", {REV, 8'hff}, {rdv, env});
        frm(1'b0, sct_pkg::ADDR_SER_CFG, 8'h00);
        chk("oe after write", 16'h0000, 16'(env));
        frm(1'b1, sct_pkg::ADDR_SER_CFG, 8'h00);
        chk("auto rd ser_cfg", 16'h00ff, {rdv, env});
        report_and_stop();
    end
endmodule
